// ---- hw/rxwa_match_if.sv ----
// pattern search request and per-offset hit vector
`timescale 1ns/100ps
interface rxwa_match_if #(parameter int W = 10);
    logic [2*W-1:0] window;
    logic [W-1:0] pat;
    logic [W-1:0] mask;
    logic dual;
    logic [W-1:0] hits;
    modport searcher (input window, input pat, input mask, input dual, output hits);
    modport user (output window, output pat, output mask, output dual, input hits);
endinterface : rxwa_match_if

// ---- hw/rxwa_pkg.sv ----
// constants, types and helpers shared by the receive word aligner
// Function
// - manual mode with search enabled scans for the 7 or 10 bit pattern, realigns
// - manual mode with search disabled keeps the boundary despite patterns elsewhere
// - first pattern after search enable rises pulses sync and hit one cycle
// - later pattern at current boundary pulses only the hit flag
// - realignment only while search enabled; each realignment pulses sync once
// - sync and hit flags leave with the same latency as their data word
// - every rising edge of slip request shifts the boundary by one bit
// - in slip mode hit pulses when two output words match the double-width pattern
// - each slip inserts one bit at the output word's most significant end
// - automatic mode acquires sync after 4 patterns at one boundary with no invalid code group between
// - automatic mode loses sync after 17 erroneous code groups
// - each run of 16 good groups lowers the error count by one
// - after reset automatic mode searches, then raises sync on acquisition
// - sync stays high until loss, then low until acquired again
// - PCIe configuration fixes pattern, its length and the thresholds
// - run-length flag rises when identical bits exceed the configured maximum
// - run-length limit spans width/2 up to 16 or 32 times width
// - selectable receive polarity inversion
// - MSB-first selection reverses the output bit order; default LSB first
// - byte reversal swaps output halves in 16 and 20 bit custom widths
// - polarity inversion unavailable in PCIe configuration
// - bit reversal available only in custom configurations
package rxwa_pkg;
    localparam int DATA_W = 10;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_PAT = 8'h04;
    localparam logic [7:0] ADR_RLV = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0C;
    // control register fields
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_SEARCH = 2;
    localparam int CTL_SLIP = 3;
    localparam int CTL_POL = 4;
    localparam int CTL_BREV = 5;
    localparam int CTL_BYREV = 6;
    localparam int CTL_PCIE = 7;
    localparam int CTL_PLEN7 = 8;
    // status register fields
    localparam int ST_SYNC = 0;
    localparam int ST_RLV = 1;
    localparam int ST_HIT = 2;
    localparam int ST_OFF_LSB = 8;
    localparam int ST_ERR_LSB = 16;
    localparam int ST_STATE_LSB = 24;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PAT_RST = 32'h0000_017C;
    localparam logic [9:0] RLV_RST = 10'h0A0;
    localparam logic [9:0] PCIE_COMMA = 10'h17C;
    localparam logic [9:0] PLEN7_MASK = 10'h07F;
    // fixed sync hysteresis for the PCIe configuration
    localparam logic [2:0] ACQ_GROUPS = 3'd4;
    localparam logic [4:0] LOSS_ERRS = 5'd17;
    localparam logic [4:0] GOOD_RUN = 5'd16;
    localparam logic [3:0] CG_ONES_MIN = 4'd4;
    localparam logic [3:0] CG_ONES_MAX = 4'd6;
    localparam int RL_CNT_W = 10;

    typedef enum logic [1:0] {RXWA_MODE_MANUAL, RXWA_MODE_SLIP, RXWA_MODE_AUTO} rxwa_mode_t;
    typedef enum logic [1:0] {SY_LOSS, SY_ACQ, SY_SYNC} rxwa_sync_t;

    function automatic int rxwa_rl_max(input int w);
        rxwa_rl_max = (w <= 10) ? 16 * w : 32 * w;
    endfunction : rxwa_rl_max
endpackage : rxwa_pkg

// ---- hw/rxwa_run_check.sv ----
// counts runs of identical bits across words and flags overlong runs
`timescale 1ns/100ps
module rxwa_run_check
    import rxwa_pkg::*;
#(
    parameter int W = 10
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [W-1:0] din,
    input wire logic [RL_CNT_W-1:0] limit,
    output logic viol
);
    typedef struct packed {
        logic [RL_CNT_W-1:0] cnt;
        logic last;
        logic viol;
    } rxwa_rc_t;
    rxwa_rc_t r, n;

    always_comb begin
        n = r;
        n.viol = 1'b0;
        for (int i = 0; i < W; i++) begin
            if (din[i] == n.last) begin
                // saturate so a stuck line keeps flagging
                if (n.cnt != '1) begin
                    n.cnt = n.cnt + 1'b1;
                end
            end else begin
                n.cnt = RL_CNT_W'(1);
                n.last = din[i];
            end
            if (n.cnt > limit) begin
                n.viol = 1'b1;
            end
        end
        if (srst) begin
            n = '0;
        end
    end

    always_ff @(posedge mclk) begin
        r <= n;
    end

    assign viol = r.viol;
endmodule : rxwa_run_check

// ---- hw/rxwa_searcher.sv ----
// compares the pattern against every bit offset of a two-word window
`timescale 1ns/100ps
module rxwa_searcher #(
    parameter int W = 10
) (
    rxwa_match_if.searcher m
);
    genvar k;
    generate
        for (k = 0; k < W; k++) begin : g_off
            // dual catches the opposite-disparity comma
            assign m.hits[k] = (((m.window[k +: W] ^ m.pat) & m.mask) == '0)
                | (m.dual & (((m.window[k +: W] ^ ~m.pat) & m.mask) == '0));
        end
    endgenerate
endmodule : rxwa_searcher

// ---- hw/rxwa_top.sv ----
// receive word aligner with manual, bit-slip and automatic sync modes
`timescale 1ns/100ps
module rxwa_top
    import rxwa_pkg::*;
#(
    parameter int W = DATA_W
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [W-1:0] rx_data,
    output logic [W-1:0] rx_parallel_data,
    output logic sync_flag,
    output logic pattern_hit,
    output logic rlv_flag,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import rxwa_pkg::*;

    localparam int OW = $clog2(W);
    localparam int RL_MIN = W / 2;
    localparam int RL_MAX = rxwa_rl_max(W);

    typedef struct packed {
        logic [31:0] ctrl;
        logic [2*W-1:0] pat;
        logic [RL_CNT_W-1:0] rlv_lim;
        logic [W-1:0] prev;
        logic [OW-1:0] off;
        logic slip_d;
        logic search_d;
        logic armed;
        logic [W-1:0] last_out;
        logic [2:0] acq;
        logic [4:0] err;
        logic [4:0] good;
        rxwa_sync_t sstate;
        logic hit_sticky;
        logic rlv_sticky;
        logic sync;
        logic hit;
        logic rlv;
        logic [W-1:0] dout;
        logic ack;
        logic [31:0] rdata;
    } rxwa_state_t;

    rxwa_state_t r, n;
    rxwa_match_if #(.W(W)) mi ();
    logic pcie;
    logic [W-1:0] din;
    logic [RL_CNT_W-1:0] lim;
    logic rc_viol;

    function automatic logic [W-1:0] pick(input logic [2*W-1:0] win, input logic [OW-1:0] o);
        pick = win[o +: W];
    endfunction : pick

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                merge[8*i +: 8] = wd[8*i +: 8];
            end
        end
    endfunction : merge

    function automatic logic cg_valid(input logic [W-1:0] w);
        logic [3:0] ones;
        ones = '0;
        for (int i = 0; i < 10 && i < W; i++) begin
            ones = ones + 4'(w[i]);
        end
        cg_valid = (ones >= CG_ONES_MIN) && (ones <= CG_ONES_MAX);
    endfunction : cg_valid

    assign pcie = r.ctrl[CTL_PCIE];
    assign din = rx_data ^ {W{r.ctrl[CTL_POL] & ~pcie}};
    // newest word sits high, so slipping pulls fresh bits into the msb
    assign mi.window = {din, r.prev};
    assign mi.pat = pcie ? W'(PCIE_COMMA) : r.pat[W-1:0];
    assign mi.mask = (pcie | ~r.ctrl[CTL_PLEN7]) ? {W{1'b1}} : W'(PLEN7_MASK);
    assign mi.dual = pcie;
    // out-of-range limits are clamped rather than rejected
    assign lim = (r.rlv_lim < RL_CNT_W'(RL_MIN)) ? RL_CNT_W'(RL_MIN)
        : (r.rlv_lim > RL_CNT_W'(RL_MAX)) ? RL_CNT_W'(RL_MAX) : r.rlv_lim;

    rxwa_searcher #(.W(W)) u_search (
        .m(mi)
    );

    rxwa_run_check #(.W(W)) u_run (
        .mclk(mclk),
        .srst(srst),
        .din(din),
        .limit(lim),
        .viol(rc_viol)
    );

    always_comb begin
        logic [1:0] mode;
        logic search;
        logic armed_now;
        logic fh_ok;
        logic [OW-1:0] fh_off;
        logic cur_hit;
        logic [OW-1:0] new_off;
        logic sync_p;
        logic hit_p;
        logic [W-1:0] al_cur;
        logic [W-1:0] al;
        logic [W-1:0] w;
        logic acc;
        logic wr;
        logic [31:0] tmp;
        logic [31:0] stat;
        n = r;
        w = '0;
        acc = 1'b0;
        wr = 1'b0;
        tmp = '0;
        stat = '0;
        mode = pcie ? RXWA_MODE_AUTO : r.ctrl[CTL_MODE_LSB +: 2];
        search = r.ctrl[CTL_SEARCH];
        armed_now = r.armed | (search & ~r.search_d);
        fh_ok = 1'b0;
        fh_off = '0;
        for (int k = W - 1; k >= 0; k--) begin
            if (mi.hits[k]) begin
                fh_ok = 1'b1;
                fh_off = OW'(k);
            end
        end
        cur_hit = mi.hits[r.off];
        new_off = r.off;
        sync_p = 1'b0;
        hit_p = 1'b0;
        al_cur = pick(mi.window, r.off);
        al = al_cur;
        n.prev = din;
        n.search_d = search;
        n.slip_d = r.ctrl[CTL_SLIP];
        case (mode)
            RXWA_MODE_SLIP: begin
                if (r.ctrl[CTL_SLIP] & ~r.slip_d) begin
                    new_off = (r.off == OW'(W - 1)) ? '0 : OW'(r.off + 1'b1);
                end
                al = pick(mi.window, new_off);
                hit_p = ({al, r.last_out} == r.pat);
            end
            RXWA_MODE_AUTO: begin
                case (r.sstate)
                    SY_LOSS: begin
                        if (fh_ok) begin
                            new_off = fh_off;
                            hit_p = 1'b1;
                            n.acq = 3'd1;
                            n.sstate = SY_ACQ;
                        end
                    end
                    SY_ACQ: begin
                        if (!cg_valid(al_cur)) begin
                            n.acq = '0;
                            n.sstate = SY_LOSS;
                        end else if (cur_hit) begin
                            hit_p = 1'b1;
                            if (r.acq == ACQ_GROUPS - 3'd1) begin
                                n.sstate = SY_SYNC;
                                n.err = '0;
                                n.good = '0;
                            end else begin
                                n.acq = r.acq + 3'd1;
                            end
                        end
                    end
                    SY_SYNC: begin
                        hit_p = cur_hit;
                        if (!cg_valid(al_cur)) begin
                            n.good = '0;
                            if (r.err == LOSS_ERRS - 5'd1) begin
                                n.sstate = SY_LOSS;
                                n.acq = '0;
                            end else begin
                                n.err = r.err + 5'd1;
                            end
                        end else if (r.good == GOOD_RUN - 5'd1) begin
                            n.good = '0;
                            if (r.err != '0) begin
                                n.err = r.err - 5'd1;
                            end
                        end else begin
                            n.good = r.good + 5'd1;
                        end
                    end
                    default: begin
                        n.sstate = SY_LOSS;
                    end
                endcase
                al = pick(mi.window, new_off);
            end
            default: begin
                // a straddling pattern realigns only while search stays high
                if (search && fh_ok && (armed_now || !cur_hit)) begin
                    new_off = cur_hit ? r.off : fh_off;
                    sync_p = 1'b1;
                    hit_p = 1'b1;
                    n.armed = 1'b0;
                end else begin
                    hit_p = cur_hit;
                    n.armed = armed_now & search;
                end
                al = pick(mi.window, new_off);
            end
        endcase
        n.off = new_off;
        n.last_out = al;
        w = al;
        if (r.ctrl[CTL_BREV] & ~pcie) begin
            w = {<<{al}};
        end
        if ((W >= 16) && r.ctrl[CTL_BYREV] && !pcie) begin
            w = {w[W/2-1:0], w[W-1:W/2]};
        end
        // data and flags leave in the same register stage
        n.dout = w;
        n.sync = (mode == RXWA_MODE_AUTO) ? (n.sstate == SY_SYNC) : sync_p;
        n.hit = hit_p;
        n.rlv = rc_viol;
        // wishbone classic slave, ack registered one cycle after the request, held one cycle then drops
        acc = wb_cyc_i & wb_stb_i & ~r.ack;
        wr = acc & wb_we_i;
        n.ack = acc;
        n.hit_sticky = r.hit_sticky | hit_p;
        n.rlv_sticky = r.rlv_sticky | rc_viol;
        if (wr) begin
            case ({wb_adr_i[7:2], 2'b00})
                ADR_CTRL: begin
                    n.ctrl = merge(r.ctrl, wb_dat_i, wb_sel_i);
                end
                ADR_PAT: begin
                    tmp = merge(32'(r.pat), wb_dat_i, wb_sel_i);
                    n.pat = tmp[2*W-1:0];
                end
                ADR_RLV: begin
                    tmp = merge(32'(r.rlv_lim), wb_dat_i, wb_sel_i);
                    n.rlv_lim = tmp[RL_CNT_W-1:0];
                end
                ADR_STAT: begin
                    // a new event in the clear cycle keeps its bit set
                    if (wb_sel_i[0]) begin
                        n.rlv_sticky = rc_viol | (r.rlv_sticky & ~wb_dat_i[ST_RLV]);
                        n.hit_sticky = hit_p | (r.hit_sticky & ~wb_dat_i[ST_HIT]);
                    end
                end
                default: begin
                end
            endcase
        end
        stat = '0;
        stat[ST_SYNC] = r.sync;
        stat[ST_RLV] = r.rlv_sticky;
        stat[ST_HIT] = r.hit_sticky;
        stat[ST_OFF_LSB +: OW] = r.off;
        stat[ST_ERR_LSB +: 5] = r.err;
        stat[ST_STATE_LSB +: 2] = r.sstate;
        case ({wb_adr_i[7:2], 2'b00})
            ADR_CTRL: n.rdata = r.ctrl;
            ADR_PAT: n.rdata = 32'(r.pat);
            ADR_RLV: n.rdata = 32'(r.rlv_lim);
            ADR_STAT: n.rdata = stat;
            default: n.rdata = '0;
        endcase
        if (!acc) begin
            n.rdata = '0;
        end
        if (srst) begin
            n = '0;
            n.ctrl = CTRL_RST;
            n.pat = (2*W)'(PAT_RST);
            n.rlv_lim = RLV_RST;
        end
    end

    always_ff @(posedge mclk) begin
        r <= n;
    end

    assign rx_parallel_data = r.dout;
    assign sync_flag = r.sync;
    assign pattern_hit = r.hit;
    assign rlv_flag = r.rlv;
    assign wb_dat_o = r.rdata;
    assign wb_ack_o = r.ack;
endmodule : rxwa_top

// ---- tb/rxwa_deser.sv ----
// serial source model: a symbol stream cut into words at a chosen bit phase
`timescale 1ns/100ps
module rxwa_deser
    import rxwa_pkg::*;
(
    input wire logic mclk,
    input wire logic [DATA_W-1:0] sym,
    input wire logic [3:0] phase,
    output logic [DATA_W-1:0] rx_data
);
    logic [DATA_W-1:0] prev_reg;
    logic [2*DATA_W-1:0] pair;
    always_ff @(posedge mclk) begin
        prev_reg <= sym;
    end
    // each symbol starts phase bits into a word, so at nonzero phase it straddles two words
    assign pair = {sym, prev_reg};
    assign rx_data = pair[DATA_W - int'(phase) +: DATA_W];
endmodule : rxwa_deser

// ---- tb/rxwa_monitor.sv ----
// assertion checker for the receive word aligner, bound to its top module
`timescale 1ns/100ps
module rxwa_monitor
    import rxwa_pkg::*;
#(
    parameter int W = DATA_W
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [W-1:0] rx_data,
    input wire logic [W-1:0] rx_parallel_data,
    input wire logic sync_flag,
    input wire logic pattern_hit,
    input wire logic rlv_flag,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic auto_m;
    logic manual;
    logic search;
    // shadow of the control word; updated on the edge that takes the write
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[7:2] == 6'h00) begin
            if (wb_sel_i[0]) ctrl_next[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) ctrl_next[15:8] = wb_dat_i[15:8];
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) ctrl_reg <= 16'h0000;
        else ctrl_reg <= ctrl_next;
    end
    assign auto_m = ctrl_reg[CTL_PCIE] || ctrl_reg[1:0] == 2'd2;
    assign manual = !auto_m && ctrl_reg[1:0] != 2'd1;
    assign search = ctrl_reg[CTL_SEARCH];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("ack missing one cycle after request");
    property p_ack_drop;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("ack held longer than one cycle");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data not zero outside ack");
    // reset itself is the cause here, so no disable
    property p_quiet;
        disable iff (1'b0) srst |=> !sync_flag && !pattern_hit && !rlv_flag && !wb_ack_o;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("outputs active after reset edge");
    property p_sync_pulse;
        manual && sync_flag |=> !sync_flag;
    endproperty
    a_sync_pulse: assert property (p_sync_pulse)
        else $error("manual sync pulse longer than one cycle");
    property p_sync_hit;
        manual && sync_flag |-> pattern_hit;
    endproperty
    a_sync_hit: assert property (p_sync_hit)
        else $error("manual sync without pattern hit");
    // three quiet cycles cover words already in the pipeline
    property p_hold;
        manual && !search && !$past(search) && !$past(search, 2) && !$past(search, 3) |-> !sync_flag;
    endproperty
    a_hold: assert property (p_hold)
        else $error("realigned with search disabled");
    property p_auto_hold;
        auto_m && $rose(sync_flag) |=> sync_flag [*8];
    endproperty
    a_auto_hold: assert property (p_auto_hold)
        else $error("auto sync dropped too soon");
    property p_auto_low;
        auto_m && $fell(sync_flag) |=> !sync_flag [*3];
    endproperty
    a_auto_low: assert property (p_auto_low)
        else $error("auto sync regained too soon");
endmodule : rxwa_monitor

bind rxwa_top rxwa_monitor #(.W(W)) u_mon (.mclk(mclk), .srst(srst), .rx_data(rx_data),
    .rx_parallel_data(rx_parallel_data), .sync_flag(sync_flag), .pattern_hit(pattern_hit),
    .rlv_flag(rlv_flag), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

// ---- tb/tb.sv ----
// self-checking bench for the receive word aligner
`timescale 1ns/100ps
module tb;
    import rxwa_pkg::*;
    localparam logic [9:0] IDLE = 10'h155;
    localparam logic [9:0] ONES = 10'h3FF;
    localparam logic [9:0] COM = PCIE_COMMA;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [9:0] sym = IDLE;
    logic [3:0] phase = 4'h3;
    logic [9:0] rx_data;
    logic [9:0] rx_parallel_data;
    logic sync_flag;
    logic pattern_hit;
    logic rlv_flag;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [31:0] rdat;
    int num_errors = 0;
    int total_checks = 0;
    always #50 mclk = ~mclk;
    rxwa_deser src (.mclk(mclk), .sym(sym), .phase(phase), .rx_data(rx_data));
    rxwa_top #(.W(10)) dut (.mclk(mclk), .srst(srst), .rx_data(rx_data), .rx_parallel_data(rx_parallel_data),
        .sync_flag(sync_flag), .pattern_hit(pattern_hit), .rlv_flag(rlv_flag), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // classic cycle: hold until ack is sampled, release, then one idle cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        check("wb_ack_o", 32'h0000_0001, 32'(wb_ack_o));
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge mclk);
    endtask : wb
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0000_0000);
        check("wb_dat_o", exp, rdat);
    endtask : rd
    task automatic put(input logic [9:0] s, input int n);
        repeat (n) begin
            sym <= s;
            @(posedge mclk);
        end
    endtask : put
    task automatic flag(input string what, input logic exp);
        @(negedge mclk);
        check(what, 32'(exp), what == "sync_flag" ? 32'(sync_flag) : 32'(rlv_flag));
        @(posedge mclk);
    endtask : flag
    // one symbol; its aligned word stands for one cycle two edges later
    task automatic word(input logic [9:0] s, input logic [9:0] d, input logic [9:0] m, input logic sy,
        input logic ht);
        put(s, 1);
        put(IDLE, 1);
        @(negedge mclk);
        check("rx_parallel_data", 32'(d & m), 32'(rx_parallel_data & m));
        check("sync_flag", 32'(sy), 32'(sync_flag));
        check("pattern_hit", 32'(ht), 32'(pattern_hit));
        @(posedge mclk);
    endtask : word
    // slip mode needs the repeated word kept on the line
    task automatic slipped(input logic [9:0] d, input logic ht);
        put(10'h3E0, 2);
        @(negedge mclk);
        check("rx_parallel_data", 32'(d), 32'(rx_parallel_data));
        check("sync_flag", 32'h0000_0000, 32'(sync_flag));
        check("pattern_hit", 32'(ht), 32'(pattern_hit));
        @(posedge mclk);
    endtask : slipped
    task automatic do_reset();
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
    endtask : do_reset
    initial begin
        #2_000_000;
        num_errors++;
        $display("[FAIL] watchdog expected done seen timeout");
        results();
    end
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd(ADR_CTRL, CTRL_RST);
        rd(ADR_PAT, PAT_RST);
        rd(ADR_RLV, 32'(RLV_RST));
        rd(ADR_STAT, 32'h0000_0000);
        wb(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0000_0000);
        wb(1'b1, ADR_CTRL, 32'h0000_0004);
        word(COM, COM, 10'h3FF, 1'b1, 1'b1);
        word(COM, COM, 10'h3FF, 1'b0, 1'b1);
        wb(1'b1, ADR_CTRL, 32'h0000_0000);
        phase <= 4'h6;
        // offset 3 now straddles the comma and the idle before it
        word(COM, 10'h3E2, 10'h3FF, 1'b0, 1'b0);
        phase <= 4'h3;
        word(COM, COM, 10'h3FF, 1'b0, 1'b1);
        wb(1'b1, ADR_CTRL, 32'h0000_0004);
        phase <= 4'h6;
        word(COM, COM, 10'h3FF, 1'b1, 1'b1);
        wb(1'b1, ADR_CTRL, 32'h0000_0024);
        word(COM, 10'h0FA, 10'h3FF, 1'b0, 1'b1);
        wb(1'b1, ADR_CTRL, 32'h0000_0014);
        word(~COM, COM, 10'h3FF, 1'b0, 1'b1);
        wb(1'b1, ADR_CTRL, 32'h0000_0000);
        wb(1'b1, ADR_RLV, 32'h0000_0005);
        put(10'h1F0, 8);
        flag("rlv_flag", 1'b0);
        put(10'h1F8, 6);
        flag("rlv_flag", 1'b1);
        put(IDLE, 8);
        flag("rlv_flag", 1'b0);
        rd(ADR_STAT, 32'h0000_0606);
        wb(1'b1, ADR_STAT, 32'h0000_0006);
        rd(ADR_STAT, 32'h0000_0600);
        do_reset();
        phase <= 4'h0;
        put(10'h3E0, 1);
        wb(1'b1, ADR_CTRL, 32'h0000_0001);
        wb(1'b1, ADR_PAT, 32'h0003_E0F8);
        wb(1'b1, ADR_CTRL, 32'h0000_0009);
        slipped(10'h1F0, 1'b0);
        wb(1'b1, ADR_CTRL, 32'h0000_0001);
        wb(1'b1, ADR_CTRL, 32'h0000_0009);
        slipped(10'h0F8, 1'b1);
        do_reset();
        phase <= 4'h3;
        put(IDLE, 1);
        wb(1'b1, ADR_PAT, 32'h0000_0000);
        wb(1'b1, ADR_CTRL, 32'h0000_0090);
        repeat (3) begin
            put(COM, 1);
            put(IDLE, 1);
        end
        put(IDLE, 4);
        flag("sync_flag", 1'b0);
        word(COM, COM, 10'h3FF, 1'b1, 1'b1);
        put(IDLE, 5);
        flag("sync_flag", 1'b1);
        put(ONES, 16);
        put(IDLE, 5);
        flag("sync_flag", 1'b1);
        put(IDLE, 10);
        put(ONES, 1);
        put(IDLE, 5);
        flag("sync_flag", 1'b1);
        put(ONES, 1);
        put(IDLE, 5);
        flag("sync_flag", 1'b0);
        results();
    end
endmodule : tb
